// ---- design/sfe_engine.sv ----
/*
  Frame sequencer for synchronous serial and four SPI modes, master and slave.
  Assumes bit_tick is a one-cycle pulse every half serial clock period from an
  external prescaler; pins of the far party are asynchronous to clk.
*/
module sfe_engine #(
  parameter int WORD_W = sfe_pkg::WORD_W,
  parameter int FIFO_DEPTH = sfe_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic port_enable,
  input wire logic master_slave_select_bit,
  input wire logic frame_format,
  input wire logic clock_polarity_bit,
  input wire logic clock_phase_bit,
  input wire logic [3:0] data_size,
  input wire logic bit_tick,
  input wire logic [WORD_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [WORD_W-1:0] rx_data,
  output logic rx_valid,
  output logic serial_clock_out,
  output logic clock_pad_enable_n,
  output logic frame_select_out,
  output logic serial_tx_line,
  output logic tx_pad_enable_n,
  input wire logic serial_clock_in,
  input wire logic frame_select_in,
  input wire logic serial_rx_line
);

  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic [sfe_pkg::CNT_W-1:0] bits_of(input logic [3:0] ds);
    logic [sfe_pkg::CNT_W-1:0] n;
    n = {1'b0, ds} + 5'h01;
    if (n < sfe_pkg::MIN_BITS) begin
      n = sfe_pkg::MIN_BITS;
    end
    return n;
  endfunction

  function automatic logic [WORD_W-1:0] align_msb(input logic [WORD_W-1:0] w,
                                                  input logic [sfe_pkg::CNT_W-1:0] n);
    logic [WORD_W-1:0] r;
    r = w << (WORD_W[sfe_pkg::CNT_W-1:0] - n);
    return r;
  endfunction

  sfe_stream_if #(.W(WORD_W)) txq ();
  sfe_pkg::sfe_state_t st_q, st_d;
  logic [2:0] sync_q;
  logic sck_prev_q, fsi_prev_q;
  logic ssi, late, is_master, start_ok;
  logic [sfe_pkg::CNT_W-1:0] nb, bitcnt_q, bitcnt_d;
  logic [sfe_pkg::EDGE_W-1:0] edge_q, edge_d, e_next, last_edge;
  logic idle_clk, idle_fss;
  logic m_load, m_cap, m_prop, m_push, m_drive;
  logic fss_d, sclk_d, toe_d;
  logic sck, fsi, rise, fall, cap_edge, prop_edge, en, done, s_sel, s_active;
  logic s_load, s_cap, s_prop, s_push, s_act_q, s_act_d;
  logic load, cap, prop, push;
  logic [WORD_W-1:0] sh_q, sh_d, rx_sh_q, rx_sh_d, load_word, nb_mask;
  logic first_q, first_d, drive_q, drive_d;
  logic [1:0] settle_q;

  sfe_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_txq (
    .clk(clk),
    .resetn(resetn),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out(txq.source)
  );

  sfe_sync #(.W(3)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d({serial_clock_in, frame_select_in, serial_rx_line}),
    .q(sync_q)
  );

  assign ssi = frame_format == sfe_pkg::FMT_SSI;
  assign late = clock_phase_bit | ssi;
  assign is_master = master_slave_select_bit == sfe_pkg::ROLE_MASTER;
  assign start_ok = port_enable && txq.valid;
  assign nb = bits_of(data_size);
  assign last_edge = {nb, 1'b0};
  assign e_next = edge_q + 6'h01;
  assign idle_clk = ssi ? sfe_pkg::SSI_CLK_IDLE : clock_polarity_bit;
  assign idle_fss = ssi ? sfe_pkg::SSI_FSS_IDLE : sfe_pkg::SPI_FSS_IDLE;
  assign nb_mask = ~({WORD_W{1'b1}} << nb);

  // ****************************************
  // Master sequencer
  // ****************************************
  always_comb begin
    st_d = st_q;
    edge_d = edge_q;
    m_load = 1'b0;
    m_cap = 1'b0;
    m_prop = 1'b0;
    m_push = 1'b0;
    m_drive = 1'b0;
    fss_d = frame_select_out;
    sclk_d = serial_clock_out;
    toe_d = tx_pad_enable_n;
    unique case (st_q)
      sfe_pkg::ST_IDLE: begin
        fss_d = idle_fss;
        sclk_d = idle_clk;
        toe_d = sfe_pkg::PAD_OFF_N;
        if (bit_tick && start_ok) begin
          m_load = 1'b1;
          edge_d = '0;
          toe_d = 1'b0;
          if (ssi) begin
            fss_d = 1'b1;
            sclk_d = 1'b1;
            st_d = sfe_pkg::ST_PULSE;
          end else begin
            fss_d = 1'b0;
            st_d = clock_phase_bit ? sfe_pkg::ST_RUN : sfe_pkg::ST_SETUP;
          end
        end
      end
      sfe_pkg::ST_PULSE: begin
        if (bit_tick) begin
          sclk_d = 1'b0;
          st_d = sfe_pkg::ST_RUN;
        end
      end
      sfe_pkg::ST_SETUP: begin
        if (bit_tick) begin
          m_drive = 1'b1;
          st_d = sfe_pkg::ST_RUN;
        end
      end
      sfe_pkg::ST_RUN: begin
        if (bit_tick) begin
          sclk_d = !serial_clock_out;
          edge_d = e_next;
          m_cap = e_next[0] ^ late;
          m_prop = !(e_next[0] ^ late);
          if (ssi && e_next == 6'h01) begin
            fss_d = 1'b0;
          end
          if (e_next == last_edge) begin
            st_d = sfe_pkg::ST_AFTER;
          end
        end
      end
      sfe_pkg::ST_AFTER: begin
        if (bit_tick) begin
          m_push = 1'b1;
          if (ssi && start_ok) begin
            m_load = 1'b1;
            edge_d = '0;
            fss_d = 1'b1;
            sclk_d = 1'b1;
            st_d = sfe_pkg::ST_PULSE;
          end else if (ssi) begin
            st_d = sfe_pkg::ST_IDLE;
          end else if (clock_phase_bit && start_ok) begin
            m_load = 1'b1;
            m_prop = 1'b1;
            sclk_d = !serial_clock_out;
            edge_d = 6'h01;
            st_d = sfe_pkg::ST_RUN;
          end else if (clock_phase_bit) begin
            st_d = sfe_pkg::ST_TAIL;
          end else begin
            fss_d = 1'b1;
            toe_d = sfe_pkg::PAD_OFF_N;
            st_d = sfe_pkg::ST_IDLE;
          end
        end
      end
      sfe_pkg::ST_TAIL: begin
        if (bit_tick) begin
          fss_d = 1'b1;
          toe_d = sfe_pkg::PAD_OFF_N;
          st_d = sfe_pkg::ST_IDLE;
        end
      end
    endcase
    if (!is_master) begin
      st_d = sfe_pkg::ST_IDLE;
      m_load = 1'b0;
      m_cap = 1'b0;
      m_prop = 1'b0;
      m_push = 1'b0;
      m_drive = 1'b0;
      fss_d = idle_fss;
      sclk_d = idle_clk;
      toe_d = !s_active;
    end
  end

  // ****************************************
  // Slave event decode
  // ****************************************
  assign sck = sync_q[2];
  assign fsi = sync_q[1];
  assign rise = sck && !sck_prev_q;
  assign fall = !sck && sck_prev_q;
  assign cap_edge = (ssi || clock_polarity_bit != clock_phase_bit) ? fall : rise;
  assign prop_edge = (ssi || clock_polarity_bit != clock_phase_bit) ? rise : fall;
  assign en = !is_master && port_enable && settle_q > 2'(sfe_pkg::SYNC_STAGES);
  assign done = bitcnt_q >= nb;
  assign s_sel = en && !ssi && !fsi;
  assign s_active = ssi ? s_act_q : s_sel;

  // Slave edges held off until synchronised pins settle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      settle_q <= 2'h0;
    end else if (settle_q != 2'h3) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  always_comb begin
    s_load = 1'b0;
    s_prop = 1'b0;
    s_act_d = s_act_q;
    if (en && !ssi && fsi_prev_q && !fsi) begin
      s_load = 1'b1;
    end else if (en && ssi && fall && fsi) begin
      s_load = 1'b1;
      s_act_d = 1'b1;
    end else if (s_sel && prop_edge && done && clock_phase_bit) begin
      s_load = 1'b1;
      s_prop = 1'b1;
    end else if (s_active && prop_edge && !done) begin
      s_prop = 1'b1;
    end
    s_cap = s_active && cap_edge && !done;
    s_push = s_cap && (bitcnt_q + 5'h01 == nb);
    if (s_push && ssi) begin
      s_act_d = 1'b0;
    end
    if (!en) begin
      s_act_d = 1'b0;
    end
  end

  // ****************************************
  // Shared shifters
  // ****************************************
  assign load = m_load | s_load;
  assign cap = m_cap | s_cap;
  assign prop = m_prop | s_prop;
  assign push = m_push | s_push;
  assign txq.ready = load && txq.valid;
  assign load_word = txq.valid ? align_msb(txq.data, nb) : '0;

  always_comb begin
    sh_d = sh_q;
    first_d = first_q;
    bitcnt_d = bitcnt_q;
    if (load) begin
      sh_d = load_word;
      first_d = late && !prop;
      bitcnt_d = '0;
    end else if (prop) begin
      first_d = 1'b0;
      if (!first_q) begin
        sh_d = sh_q << 1;
      end
    end
    if (cap) begin
      bitcnt_d = bitcnt_q + 5'h01;
    end
    rx_sh_d = cap ? {rx_sh_q[WORD_W-2:0], sync_q[0]} : rx_sh_q;
    if (is_master) begin
      drive_d = (st_d == sfe_pkg::ST_IDLE) ? 1'b0 : (drive_q | m_drive | m_prop);
    end else begin
      drive_d = s_active && !(s_sel && done && !clock_phase_bit);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= sfe_pkg::ST_IDLE;
      edge_q <= '0;
    end else begin
      st_q <= st_d;
      edge_q <= edge_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sh_q <= '0;
      rx_sh_q <= '0;
      first_q <= 1'b0;
      bitcnt_q <= '0;
      drive_q <= 1'b0;
      s_act_q <= 1'b0;
      sck_prev_q <= 1'b0;
      fsi_prev_q <= 1'b1;
    end else begin
      sh_q <= sh_d;
      rx_sh_q <= rx_sh_d;
      first_q <= first_d;
      bitcnt_q <= bitcnt_d;
      drive_q <= drive_d;
      s_act_q <= s_act_d;
      sck_prev_q <= sck;
      fsi_prev_q <= fsi;
    end
  end

  // ****************************************
  // Receive word output
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_data <= '0;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= push;
      if (push) begin
        rx_data <= rx_sh_d & nb_mask;
      end
    end
  end

  // ****************************************
  // Pin registers
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serial_clock_out <= sfe_pkg::SSI_CLK_IDLE;
      frame_select_out <= sfe_pkg::SSI_FSS_IDLE;
      clock_pad_enable_n <= 1'b0;
      tx_pad_enable_n <= sfe_pkg::PAD_OFF_N;
      serial_tx_line <= 1'b0;
    end else begin
      serial_clock_out <= sclk_d;
      frame_select_out <= fss_d;
      clock_pad_enable_n <= !is_master;
      tx_pad_enable_n <= toe_d;
      serial_tx_line <= drive_d ? sh_d[WORD_W-1] : 1'b0;
    end
  end

endmodule

// ---- design/sfe_pkg.sv ----
/*
  Shared constants and types of the serial frame format engine.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sfe_pkg;

  // ****************************************
  // Widths and depths
  // ****************************************
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int SYNC_STAGES = 2;
  localparam int EDGE_W = 6;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] MIN_BITS = 5'h04;

  // ****************************************
  // Encodings and reset values
  // ****************************************
  localparam logic FMT_SSI = 1'b0;
  localparam logic FMT_SPI = 1'b1;
  localparam logic ROLE_MASTER = 1'b0;
  localparam logic PAD_OFF_N = 1'b1;
  localparam logic SSI_FSS_IDLE = 1'b0;
  localparam logic SPI_FSS_IDLE = 1'b1;
  localparam logic SSI_CLK_IDLE = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PULSE,
    ST_SETUP,
    ST_RUN,
    ST_AFTER,
    ST_TAIL
  } sfe_state_t;

endpackage

// ---- design/sfe_stream_if.sv ----
/*
  Valid/ready word stream between the engine's own modules.
  Assumes both ends run on the same clock.
*/
interface sfe_stream_if #(
  parameter int W = 16
);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// ---- design/sfe_sync.sv ----
/*
  Two-stage synchroniser for a group of asynchronous pin levels.
  Assumes each bit is an independent level.
*/
module sfe_sync #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// ---- design/sfe_fifo.sv ----
/*
  Word FIFO with valid/ready on both sides and registered full flag.
  Assumes DEPTH is a power of two.
*/
module sfe_fifo #(
  parameter int W = sfe_pkg::WORD_W,
  parameter int DEPTH = sfe_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  sfe_stream_if.source out
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out.valid && out.ready;
  assign out.data = mem[rd_q];

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  // ****************************************
  // Storage
  // ****************************************
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // ****************************************
  // Pointers and flags
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
      in_ready <= 1'b0;
      out.valid <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      count_q <= count_d;
      in_ready <= count_d != DEPTH[AW:0];
      out.valid <= count_d != '0;
    end
  end

endmodule

// ---- dv/sfe_checker.sv ----
/* Pin checker for the frame engine, bound to sfe_engine.
   Assumes configuration inputs change only while resetn is low. */
module sfe_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic master_slave_select_bit,
  input wire logic frame_format,
  input wire logic clock_polarity_bit,
  input wire logic clock_phase_bit,
  input wire logic bit_tick,
  input wire logic serial_clock_out,
  input wire logic clock_pad_enable_n,
  input wire logic frame_select_out,
  input wire logic serial_tx_line,
  input wire logic tx_pad_enable_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] up_q;
  wire logic spi = frame_format == sfe_pkg::FMT_SPI;
  wire logic mst = master_slave_select_bit == sfe_pkg::ROLE_MASTER;
  wire logic ok = up_q == 2'h3;
  wire logic fso = frame_select_out;
  wire logic sco = serial_clock_out;
  wire logic pol = clock_polarity_bit;
  wire logic ssi_rest = !spi && mst && !fso && !sco;
  wire logic spi_rest = spi && mst && fso;
  logic [1:0] tk_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Settles after the reset values have left the pins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      up_q <= 2'h0;
    end else if (up_q != 2'h3) begin
      up_q <= up_q + 2'h1;
    end
  end

  // Ticks seen since select fell, saturating
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tk_q <= 2'h0;
    end else if (fso) begin
      tk_q <= 2'h0;
    end else if (bit_tick && tk_q != 2'h3) begin
      tk_q <= tk_q + 2'h1;
    end
  end

  AST_SSI_IDLE: assert property (ssi_rest[*8] ##1 ssi_rest[*4] |-> tx_pad_enable_n)
    else $error("SSI idle tx pad driven");
  AST_SSI_PULSE: assert property (ok && !spi && mst && $rose(fso) |-> $rose(sco))
    else $error("SSI pulse not on clock rise");
  AST_SSI_MSB: assert property (ok && !spi && mst && $fell(fso) |-> $rose(sco))
    else $error("SSI pulse not one period");
  AST_SPI_PARK: assert property (spi_rest |-> sco == pol)
    else $error("SPI clock not parked");
  AST_SPI_IDLE: assert property (spi_rest[*8] ##1 spi_rest[*4] |-> tx_pad_enable_n && !serial_tx_line)
    else $error("SPI idle tx pins wrong");
  AST_CLK_PAD: assert property (ok && spi |-> clock_pad_enable_n == master_slave_select_bit)
    else $error("clock pad enable wrong");
  AST_SPI_START: assert property (ok && spi && mst && $fell(fso) |-> !tx_pad_enable_n)
    else $error("tx pad off at start");
  AST_PH0_LEAD: assert property (ok && spi && mst && !clock_phase_bit && !fso && tk_q < 2'h2 |-> sco == pol)
    else $error("phase 0 clock moved too early");
  AST_PH0_EDGE: assert property (ok && spi && mst && !clock_phase_bit && !fso && tk_q == 2'h2 &&
      $past(tk_q) == 2'h1 |-> sco != pol)
    else $error("phase 0 first edge missing");
endmodule

// ---- dv/sfe_far_slave.sv ----
/* Far-side peripheral answering the engine as slave in SSI and SPI.
   Assumes the engine is master and size holds bits minus one. */
module sfe_far_slave (
  input wire logic sclk,
  input wire logic fss,
  input wire logic mosi,
  input wire logic fmt,
  input wire logic pol,
  input wire logic pha,
  input wire logic [3:0] size,
  input wire logic [15:0] reply,
  output logic miso,
  output logic [15:0] got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] sh = 16'h0000;
  int k = 0;
  initial begin
    miso = 1'b0;
    got = 16'h0000;
  end
  task automatic push();
    miso = sh[size];
    sh = sh << 1;
  endtask
  always @(fss) begin
    #1;
    if (fmt && !fss) begin
      sh = reply;
      if (!pha) push();
    end else if (fmt) begin
      // Released line must not keep its last value
      miso = ~miso;
    end
  end
  always @(sclk) begin
    #1;
    if (fmt && !fss) begin
      if ((sclk != pol) ^ pha) got = {got[14:0], mosi};
      else push();
    end else if (!fmt && sclk && fss) begin
      sh = reply;
      k = 0;
    end else if (!fmt && sclk) begin
      push();
    end else if (!fmt && !fss && k <= int'(size)) begin
      got = {got[14:0], mosi};
      k++;
    end
  end
endmodule

// ---- dv/tb_serial_frame_format_engine.sv ----
/* Self-checking bench for the frame engine with a far-side peripheral.
   Assumes package, interface and design modules are compiled first. */
module tb_serial_frame_format_engine;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic f; logic p; logic h; logic [3:0] s; logic [15:0] t; logic [15:0] r;} sfe_row_t;
  sfe_row_t rows[5] = '{'{1'b0, 1'b0, 1'b0, 4'h7, 16'hA5C3, 16'h3C96},
    '{1'b1, 1'b0, 1'b0, 4'hF, 16'hB4E1, 16'h5A0F}, '{1'b1, 1'b0, 1'b1, 4'h3, 16'h0009, 16'h0006},
    '{1'b1, 1'b1, 1'b0, 4'h6, 16'h0055, 16'h002A}, '{1'b1, 1'b1, 1'b1, 4'hB, 16'h0F3C, 16'h0A53}};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic port_enable = 1'b0;
  logic master_slave_select_bit = 1'b0;
  logic frame_format = 1'b0;
  logic clock_polarity_bit = 1'b0;
  logic clock_phase_bit = 1'b0;
  logic [3:0] data_size = 4'hF;
  logic bit_tick = 1'b0;
  logic [15:0] tx_data = 16'h0000;
  logic tx_valid = 1'b0;
  logic serial_clock_in = 1'b0;
  logic frame_select_in = 1'b1;
  logic tx_ready, rx_valid, serial_clock_out, clock_pad_enable_n, frame_select_out, serial_tx_line, tx_pad_enable_n;
  logic [15:0] rx_data, rx_q, got, mask, tx_seen;
  logic [15:0] reply = 16'h0000;
  logic b_rx = 1'b0;
  logic fs_p = 1'b0;
  logic miso;
  logic [1:0] tc = 2'h0;
  int n_fail = 0, checked = 0, n_rx = 0, n_up = 0;
  wire logic serial_rx_line = master_slave_select_bit ? b_rx : miso;

  sfe_far_slave far (.sclk(serial_clock_out), .fss(frame_select_out), .mosi(serial_tx_line), .fmt(frame_format),
    .pol(clock_polarity_bit), .pha(clock_phase_bit), .size(data_size), .reply, .miso, .got);
  sfe_engine dut (.clk, .resetn, .port_enable, .master_slave_select_bit, .frame_format, .clock_polarity_bit,
    .clock_phase_bit, .data_size, .bit_tick, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .serial_clock_out,
    .clock_pad_enable_n, .frame_select_out, .serial_tx_line, .tx_pad_enable_n, .serial_clock_in, .frame_select_in,
    .serial_rx_line);

  always #5 clk = ~clk;
  // Prescaler stand-in: one tick every four clocks
  always @(posedge clk) begin
    #1;
    tc = tc + 2'h1;
    bit_tick = tc == 2'h0;
  end
  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      n_rx++;
      rx_q = rx_data;
    end
    if (frame_select_out === 1'b1 && fs_p === 1'b0) n_up++;
    fs_p = frame_select_out;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_w(input logic [15:0] g, input logic [15:0] e, input string m);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic cfg(input logic f, input logic p, input logic h, input logic [3:0] s, input logic m);
    resetn = 1'b0;
    frame_format = f;
    clock_polarity_bit = p;
    clock_phase_bit = h;
    data_size = s;
    master_slave_select_bit = m;
    step(8);
    resetn = 1'b1;
    step(2);
    n_rx = 0;
    n_up = 0;
  endtask
  // Leaves tx_valid high so back-to-back writes need no gap
  task automatic wr(input logic [15:0] d);
    tx_data = d;
    tx_valid = 1'b1;
    @(posedge clk);
    while (tx_ready !== 1'b1) @(posedge clk);
    #1;
  endtask
  task automatic wait_rx(input int n);
    for (int j = 0; j < 3000 && n_rx < n; j++) @(posedge clk);
    step(1);
  endtask
  task automatic print_verdict();
    $display("Counts: checked %0d failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    $display("Error %0t: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    for (int i = 0; i < 5; i++) begin
      port_enable = 1'b1;
      reply = rows[i].r;
      cfg(rows[i].f, rows[i].p, rows[i].h, rows[i].s, 1'b0);
      mask = 16'hFFFF >> (4'hF - rows[i].s);
      wr(rows[i].t);
      tx_valid = 1'b0;
      wait_rx(1);
      chk_w(16'(n_rx), 16'h0001, "rx count");
      chk_w(rx_q, rows[i].r & mask, "rx word");
      chk_w(got & mask, rows[i].t & mask, "tx word");
      $display("row %0d done", i);
    end
    resetn = 1'b0;
    #1;
    chk_w({11'h000, serial_clock_out, frame_select_out, tx_pad_enable_n, tx_ready, rx_valid}, 16'h0004, "reset");
    cfg(1'b1, 1'b1, 1'b1, 4'h7, 1'b0);
    chk_w({11'h000, serial_clock_out, frame_select_out, serial_tx_line, tx_pad_enable_n, clock_pad_enable_n},
      16'h001A, "idle pins");
    $display("reset test done");
    for (int h = 0; h < 2; h++) begin
      port_enable = 1'b0;
      cfg(1'b1, 1'b0, 1'(h), 4'h7, 1'b0);
      for (int w = 0; w < 4; w++) wr(16'h00C0 + 16'(w));
      tx_data = 16'h00FF;
      step(12);
      tx_valid = 1'b0;
      chk_w({14'h0000, tx_ready, frame_select_out}, 16'h0001, "full and held");
      port_enable = 1'b1;
      wait_rx(4);
      step(40);
      chk_w(16'(n_rx), 16'h0004, "words");
      chk_w(16'(n_up), h ? 16'h0001 : 16'h0004, "select rises");
      chk_w(got & 16'h00FF, 16'h00C3, "last word");
      $display("back-to-back %0d done", h);
    end
    port_enable = 1'b1;
    cfg(1'b1, 1'b0, 1'b0, 4'hF, 1'b1);
    wr(16'h9D2B);
    tx_valid = 1'b0;
    reply = 16'h6E71;
    frame_select_in = 1'b0;
    #80;
    for (int b = 15; b >= 0; b--) begin
      b_rx = reply[b];
      #80 serial_clock_in = 1'b1;
      tx_seen = {tx_seen[14:0], serial_tx_line};
      #80 serial_clock_in = 1'b0;
    end
    #80 frame_select_in = 1'b1;
    b_rx = ~b_rx;
    wait_rx(1);
    chk_w(rx_q, 16'h6E71, "slave rx");
    chk_w(tx_seen, 16'h9D2B, "slave tx");
    $display("slave test done");
    print_verdict();
  end
endmodule

bind sfe_engine sfe_checker chk (.clk, .resetn, .master_slave_select_bit, .frame_format, .clock_polarity_bit,
  .clock_phase_bit, .bit_tick, .serial_clock_out, .clock_pad_enable_n, .frame_select_out, .serial_tx_line,
  .tx_pad_enable_n);
